// ---- energy_accum_noload_gain_config.sv ----
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
module energy_accum_noload_gain_config (
  input  wire logic                             aclk,         // clock
  input  wire logic                             aresetn,      // sync reset
  input  wire logic [meter_cfg_pkg::ADDR_W-1:0] awaddr,       // write addr
  input  wire logic [2:0]                       awprot,       // unused
  input  wire logic                             awvalid,      // addr valid
  output logic                                  awready,      // addr ready
  input  wire logic [meter_cfg_pkg::DATA_W-1:0] wdata,        // write data
  input  wire logic [3:0]                       wstrb,        // byte lanes
  input  wire logic                             wvalid,       // data valid
  output logic                                  wready,       // data ready
  output logic [1:0]                            bresp,        // write resp
  output logic                                  bvalid,       // resp valid
  input  wire logic                             bready,       // resp ready
  input  wire logic [meter_cfg_pkg::ADDR_W-1:0] araddr,       // read addr
  input  wire logic [2:0]                       arprot,       // unused
  input  wire logic                             arvalid,      // addr valid
  output logic                                  arready,      // addr ready
  output logic [meter_cfg_pkg::DATA_W-1:0]      rdata,        // read data
  output logic [1:0]                            rresp,        // read resp
  output logic                                  rvalid,       // data valid
  input  wire logic                             rready,       // data ready
  input  wire meter_cfg_pkg::power_s            power_in,     // raw power
  input  wire logic                             power_in_valid, // strobe
  output meter_cfg_pkg::power_s                 power_out,    // for accum
  output logic                                  power_out_valid, // strobe
  input  wire logic                             active_power_neg, // filt
  input  wire logic                             reactive_power_neg, // filt
  input  wire logic                             energy_pulse_output, // pulse
  input  wire logic                             energy_pulse_neg, // sign
  input  wire logic                             reactive_pulse_output, // pulse
  input  wire logic                             reactive_pulse_neg, // sign
  input  wire logic                             fault_mode,   // fault level
  input  wire logic                             tamper_channel_b, // chan
  output meter_cfg_pkg::meter_cfg_s             cfg,          // settings
  output logic                                  irq           // interrupt
);

  typedef enum logic {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } wr_state_e;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } rd_state_e;

  wr_state_e                          wr_state_r;
  wr_state_e                          wr_state_nxt;
  rd_state_e                          rd_state_r;
  rd_state_e                          rd_state_nxt;
  logic                               aw_got_r;
  logic                               aw_got_nxt;
  logic                               w_got_r;
  logic                               w_got_nxt;
  logic [7:0]                         wr_idx_r;
  logic [7:0]                         wdata_r;
  logic                               wstrb_r;
  logic                               do_write;
  logic                               wr_hit;
  logic [meter_cfg_pkg::DATA_W-1:0]   rd_data_nxt;
  logic [1:0]                         rd_resp_nxt;
  logic [7:0]                         noload_r;
  logic [7:0]                         accum_r;
  logic [7:0]                         gain_r;
  logic                               tamper_r;
  logic [meter_cfg_pkg::IRQ_W-1:0]    status_r;
  logic [meter_cfg_pkg::IRQ_W-1:0]    enable_r;
  logic [meter_cfg_pkg::IRQ_W-1:0]    clear_pls;
  logic [meter_cfg_pkg::IRQ_W-1:0]    event_pls;
  logic [meter_cfg_pkg::IRQ_W-1:0]    sgn_now;
  logic [meter_cfg_pkg::IRQ_W-1:0]    sgn_upd;
  logic [meter_cfg_pkg::IRQ_W-1:0]    sgn_pol;
  logic [meter_cfg_pkg::IRQ_W-1:0]    sgn_prev_r;
  logic [meter_cfg_pkg::IRQ_W-1:0]    sgn_seen_r;
  logic                               pulse_src;

  // write channel sequencing
  always_comb begin
    aw_got_nxt   = aw_got_r | (awvalid & awready);
    w_got_nxt    = w_got_r | (wvalid & wready);
    wr_state_nxt = wr_state_r;
    if (do_write) begin
      aw_got_nxt   = 1'b0;
      w_got_nxt    = 1'b0;
      wr_state_nxt = WR_RESP;
    end else if (wr_state_r == WR_RESP && bready) begin
      wr_state_nxt = WR_IDLE;
    end
  end

  assign do_write = (wr_state_r == WR_IDLE) && aw_got_r && w_got_r;

  assign wr_hit = (wr_idx_r == meter_cfg_pkg::IDX_NOLOAD) ||
                  (wr_idx_r == meter_cfg_pkg::IDX_ACCUM) ||
                  (wr_idx_r == meter_cfg_pkg::IDX_GAIN) ||
                  (wr_idx_r == meter_cfg_pkg::IDX_IRQ_STATUS) ||
                  (wr_idx_r == meter_cfg_pkg::IDX_IRQ_CLEAR) ||
                  (wr_idx_r == meter_cfg_pkg::IDX_IRQ_ENABLE);

  // write handshake flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_r <= WR_IDLE;
      aw_got_r   <= 1'b0;
      w_got_r    <= 1'b0;
      awready    <= 1'b0;
      wready     <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= meter_cfg_pkg::RESP_OKAY;
    end else begin
      wr_state_r <= wr_state_nxt;
      aw_got_r   <= aw_got_nxt;
      w_got_r    <= w_got_nxt;
      awready    <= (wr_state_nxt == WR_IDLE) && !aw_got_nxt;
      wready     <= (wr_state_nxt == WR_IDLE) && !w_got_nxt;
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? meter_cfg_pkg::RESP_OKAY
                         : meter_cfg_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // captured address and low data byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_idx_r <= 8'h00;
      wdata_r  <= 8'h00;
      wstrb_r  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        wr_idx_r <= awaddr[meter_cfg_pkg::ADDR_W-1:2];
      end
      if (wvalid && wready) begin
        wdata_r <= wdata[7:0];
        wstrb_r <= wstrb[0];
      end
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      noload_r <= meter_cfg_pkg::RST_NOLOAD;
      accum_r  <= meter_cfg_pkg::RST_ACCUM;
      gain_r   <= meter_cfg_pkg::RST_GAIN;
      enable_r <= '0;
    end else if (do_write && wstrb_r) begin
      case (wr_idx_r)
        meter_cfg_pkg::IDX_NOLOAD: begin
          noload_r <= wdata_r & meter_cfg_pkg::WMASK_NOLOAD;
        end
        meter_cfg_pkg::IDX_ACCUM: begin
          accum_r <= wdata_r & meter_cfg_pkg::WMASK_ACCUM;
        end
        meter_cfg_pkg::IDX_GAIN: begin
          gain_r <= wdata_r & meter_cfg_pkg::WMASK_GAIN;
        end
        meter_cfg_pkg::IDX_IRQ_ENABLE: begin
          enable_r <= wdata_r[meter_cfg_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tamper_r <= 1'b0;
    end else begin
      tamper_r <= tamper_channel_b;
    end
  end

  // read data selection
  always_comb begin
    rd_data_nxt = '0;
    rd_resp_nxt = meter_cfg_pkg::RESP_OKAY;
    case (araddr[meter_cfg_pkg::ADDR_W-1:2])
      meter_cfg_pkg::IDX_NOLOAD: begin
        rd_data_nxt[7:0] = noload_r;
      end
      meter_cfg_pkg::IDX_ACCUM: begin
        rd_data_nxt[7:0] = accum_r;
        rd_data_nxt[meter_cfg_pkg::ACC_TAMPER_BIT] = tamper_r;
      end
      meter_cfg_pkg::IDX_GAIN: begin
        rd_data_nxt[7:0] = gain_r;
      end
      meter_cfg_pkg::IDX_IRQ_STATUS: begin
        rd_data_nxt[meter_cfg_pkg::IRQ_W-1:0] = status_r;
      end
      meter_cfg_pkg::IDX_IRQ_CLEAR: begin
        rd_data_nxt = '0;
      end
      meter_cfg_pkg::IDX_IRQ_ENABLE: begin
        rd_data_nxt[meter_cfg_pkg::IRQ_W-1:0] = enable_r;
      end
      default: begin
        rd_resp_nxt = meter_cfg_pkg::RESP_SLVERR;
      end
    endcase
  end

  // read channel
  always_comb begin
    rd_state_nxt = rd_state_r;
    if (rd_state_r == RD_IDLE && arvalid && arready) begin
      rd_state_nxt = RD_DATA;
    end else if (rd_state_r == RD_DATA && rready) begin
      rd_state_nxt = RD_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= RD_IDLE;
      arready    <= 1'b0;
      rvalid     <= 1'b0;
      rdata      <= '0;
      rresp      <= meter_cfg_pkg::RESP_OKAY;
    end else begin
      rd_state_r <= rd_state_nxt;
      arready    <= (rd_state_nxt == RD_IDLE);
      rvalid     <= (rd_state_nxt == RD_DATA);
      if (rd_state_r == RD_IDLE && arvalid && arready) begin
        rdata <= rd_data_nxt;
        rresp <= rd_resp_nxt;
      end
    end
  end

  assign pulse_src = gain_r[meter_cfg_pkg::GAIN_SRC_BIT];

  // per event: current sign, update strobe, trigger polarity
  always_comb begin
    sgn_now[meter_cfg_pkg::IRQ_AP]    = pulse_src ? energy_pulse_neg
                                                  : active_power_neg;
    sgn_upd[meter_cfg_pkg::IRQ_AP]    = pulse_src ? energy_pulse_output
                                                  : 1'b1;
    sgn_pol[meter_cfg_pkg::IRQ_AP]    =
      accum_r[meter_cfg_pkg::ACC_APSGN_BIT];
    sgn_now[meter_cfg_pkg::IRQ_VAR]   = pulse_src ? reactive_pulse_neg
                                                  : reactive_power_neg;
    sgn_upd[meter_cfg_pkg::IRQ_VAR]   = pulse_src ? reactive_pulse_output
                                                  : 1'b1;
    sgn_pol[meter_cfg_pkg::IRQ_VAR]   =
      accum_r[meter_cfg_pkg::ACC_VARSGN_BIT];
    sgn_now[meter_cfg_pkg::IRQ_FAULT] = fault_mode;
    sgn_upd[meter_cfg_pkg::IRQ_FAULT] = 1'b1;
    sgn_pol[meter_cfg_pkg::IRQ_FAULT] =
      accum_r[meter_cfg_pkg::ACC_FAULT_BIT];
  end

  // one edge detector per event source
  for (genvar i = 0; i < meter_cfg_pkg::IRQ_W; i++) begin : g_edge
    assign event_pls[i] = sgn_upd[i] && sgn_seen_r[i] &&
                          (sgn_prev_r[i] != sgn_now[i]) &&
                          (sgn_now[i] != sgn_pol[i]);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sgn_prev_r[i] <= 1'b0;
        sgn_seen_r[i] <= 1'b0;
      end else if (sgn_upd[i]) begin
        sgn_prev_r[i] <= sgn_now[i];
        sgn_seen_r[i] <= 1'b1;
      end
    end
  end

  assign clear_pls = (do_write && wstrb_r &&
                      wr_idx_r == meter_cfg_pkg::IDX_IRQ_CLEAR) ?
                     wdata_r[meter_cfg_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
      irq      <= 1'b0;
    end else begin
      status_r <= (status_r & ~clear_pls) | event_pls;
      irq      <= |(status_r & enable_r);
    end
  end

  // accumulation sign shaping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_out       <= '0;
      power_out_valid <= 1'b0;
    end else begin
      power_out_valid <= power_in_valid;
      if (power_in_valid) begin
        if (accum_r[meter_cfg_pkg::ACC_APABS_BIT] &&
            power_in.active < 0) begin
          power_out.active <= -power_in.active;
        end else if (accum_r[meter_cfg_pkg::ACC_APPOS_BIT] &&
                     !accum_r[meter_cfg_pkg::ACC_APABS_BIT] &&
                     power_in.active < 0) begin
          power_out.active <= '0;
        end else begin
          power_out.active <= power_in.active;
        end
        if (accum_r[meter_cfg_pkg::ACC_VARABS_BIT]) begin
          power_out.reactive <= (power_in.reactive < 0) ?
                                -power_in.reactive : power_in.reactive;
        end else if (accum_r[meter_cfg_pkg::ACC_VARSA_BIT] &&
                     power_in.active < 0) begin
          power_out.reactive <= -power_in.reactive;
        end else begin
          power_out.reactive <= power_in.reactive;
        end
      end
    end
  end

  // decoded settings for the datapath
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= '0;
    end else begin
      cfg.var_freq_comp_enable <=
        !noload_r[meter_cfg_pkg::NL_VARCMP_BIT];
      cfg.current_rms_noload_enable <=
        noload_r[meter_cfg_pkg::NL_IRMS_BIT];
      cfg.current_rms_th <= noload_r[meter_cfg_pkg::NL_IRMS_BIT] ?
        meter_cfg_pkg::th_apparent(
          noload_r[meter_cfg_pkg::NL_VA_LSB +: 2]) :
        meter_cfg_pkg::TH_OFF;
      cfg.apparent_th <= meter_cfg_pkg::th_apparent(
        noload_r[meter_cfg_pkg::NL_VA_LSB +: 2]);
      cfg.reactive_th <= meter_cfg_pkg::th_power(
        noload_r[meter_cfg_pkg::NL_VAR_LSB +: 2]);
      cfg.active_th <= meter_cfg_pkg::th_power(
        noload_r[meter_cfg_pkg::NL_AP_LSB +: 2]);
      cfg.current_gain <= meter_cfg_pkg::gain_factor(
        gain_r[meter_cfg_pkg::GAIN_I_LSB +: 3]);
      cfg.voltage_gain <= meter_cfg_pkg::gain_factor(
        gain_r[meter_cfg_pkg::GAIN_V_LSB +: 3]);
      cfg.sign_detect_source <= pulse_src;
    end
  end

endmodule

// ---- meter_cfg_pkg.sv ----
package meter_cfg_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_NOLOAD     = 8'h0e;
  localparam logic [7:0] IDX_ACCUM      = 8'h0f;
  localparam logic [7:0] IDX_GAIN       = 8'h1b;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h21;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h22;

  // reset values
  localparam logic [7:0] RST_NOLOAD = 8'h00;
  localparam logic [7:0] RST_ACCUM  = 8'h00;
  localparam logic [7:0] RST_GAIN   = 8'h00;

  // writable bit masks
  localparam logic [7:0] WMASK_NOLOAD = 8'hff;
  localparam logic [7:0] WMASK_ACCUM  = 8'h7f;
  localparam logic [7:0] WMASK_GAIN   = 8'hef;

  // noload field positions
  localparam int unsigned NL_VARCMP_BIT = 7;
  localparam int unsigned NL_IRMS_BIT   = 6;
  localparam int unsigned NL_VA_LSB     = 4;
  localparam int unsigned NL_VAR_LSB    = 2;
  localparam int unsigned NL_AP_LSB     = 0;

  // accumulation field positions
  localparam int unsigned ACC_TAMPER_BIT = 7;
  localparam int unsigned ACC_FAULT_BIT  = 6;
  localparam int unsigned ACC_VARSGN_BIT = 5;
  localparam int unsigned ACC_APSGN_BIT  = 4;
  localparam int unsigned ACC_VARABS_BIT = 3;
  localparam int unsigned ACC_VARSA_BIT  = 2;
  localparam int unsigned ACC_APPOS_BIT  = 1;
  localparam int unsigned ACC_APABS_BIT  = 0;

  // gain field positions
  localparam int unsigned GAIN_V_LSB   = 5;
  localparam int unsigned GAIN_SRC_BIT = 3;
  localparam int unsigned GAIN_I_LSB   = 0;
  localparam logic [2:0]  GAIN_MAX_CODE = 3'h4;
  localparam logic [4:0]  GAIN_UNITY    = 5'h01;

  // interrupt bits
  localparam int unsigned IRQ_W     = 3;
  localparam int unsigned IRQ_AP    = 0;
  localparam int unsigned IRQ_VAR   = 1;
  localparam int unsigned IRQ_FAULT = 2;

  // thresholds in tenths of ppm of full scale
  localparam logic [15:0] TH_OFF    = 16'h0000;
  localparam logic [15:0] TH_0P030  = 16'h0bb8; // 0.030 %
  localparam logic [15:0] TH_0P015  = 16'h05dc; // 0.015 %
  localparam logic [15:0] TH_0P0075 = 16'h02ee; // 0.0075 %
  localparam logic [15:0] TH_0P0037 = 16'h0172; // 0.0037 %

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [1:0] noload_lvl_t;
  typedef logic [2:0] gain_code_t;

  typedef struct packed {
    logic        var_freq_comp_enable;
    logic        current_rms_noload_enable;
    logic [15:0] apparent_th;
    logic [15:0] reactive_th;
    logic [15:0] active_th;
    logic [15:0] current_rms_th;
    logic [4:0]  current_gain;
    logic [4:0]  voltage_gain;
    logic        sign_detect_source;
  } meter_cfg_s;

  typedef struct packed {
    logic signed [31:0] active;
    logic signed [31:0] reactive;
  } power_s;

  // apparent and current rms scale
  function automatic logic [15:0] th_apparent(input noload_lvl_t code);
    case (code)
      2'h1:    return TH_0P030;
      2'h2:    return TH_0P015;
      2'h3:    return TH_0P0075;
      default: return TH_OFF;
    endcase
  endfunction

  // active and reactive scale
  function automatic logic [15:0] th_power(input noload_lvl_t code);
    case (code)
      2'h1:    return TH_0P015;
      2'h2:    return TH_0P0075;
      2'h3:    return TH_0P0037;
      default: return TH_OFF;
    endcase
  endfunction

  // reserved codes fall back to unity
  function automatic logic [4:0] gain_factor(input gain_code_t code);
    if (code <= GAIN_MAX_CODE) begin
      return GAIN_UNITY << code;
    end
    return GAIN_UNITY;
  endfunction

endpackage

// ---- energy_accum_noload_gain_config_properties.sv ----
`timescale 1ns/1ns
module energy_accum_noload_gain_config_properties (
  input wire logic                      aclk,            // clock
  input wire logic                      aresetn,         // sync reset
  input wire logic                      bvalid,          // write answer
  input wire logic                      bready,          // answer taken
  input wire logic                      rvalid,          // read answer
  input wire logic                      rready,          // answer taken
  input wire logic [1:0]                rresp,           // read status
  input wire logic                      power_in_valid,  // sample in
  input wire logic                      power_out_valid, // sample out
  input wire meter_cfg_pkg::power_s     power_in,        // raw power
  input wire meter_cfg_pkg::power_s     power_out,       // shaped power
  input wire logic                      irq,             // interrupt
  input wire meter_cfg_pkg::meter_cfg_s cfg              // settings
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // gains are one of 1, 2, 4, 8, 16
  AST_GAIN_I: assert property (
    $past(aresetn) |-> $onehot(cfg.current_gain))
    else $error("current gain out of range");
  AST_GAIN_V: assert property (
    $past(aresetn) |-> $onehot(cfg.voltage_gain))
    else $error("voltage gain out of range");
  // thresholds only from the decode tables
  AST_TH_VA: assert property (
    cfg.apparent_th inside {16'h0000, 16'h0bb8, 16'h05dc, 16'h02ee})
    else $error("apparent threshold off table");
  AST_TH_VAR: assert property (
    cfg.reactive_th inside {16'h0000, 16'h05dc, 16'h02ee, 16'h0172})
    else $error("reactive threshold off table");
  AST_TH_AP: assert property (
    cfg.active_th inside {16'h0000, 16'h05dc, 16'h02ee, 16'h0172})
    else $error("active threshold off table");
  // current rms level follows apparent level when enabled, else off
  AST_IRMS_ON: assert property (
    cfg.current_rms_noload_enable |-> cfg.current_rms_th == cfg.apparent_th)
    else $error("current rms threshold wrong");
  AST_IRMS_OFF: assert property (
    !cfg.current_rms_noload_enable |-> cfg.current_rms_th == 16'h0000)
    else $error("current rms threshold not off");
  // power path answers one cycle after each strobe
  AST_PWR_STRB: assert property (
    power_in_valid |=> power_out_valid)
    else $error("power strobe lost");
  AST_PWR_IDLE: assert property (
    !power_in_valid |=> !power_out_valid)
    else $error("power strobe without input");
  // non-negative active power passes unchanged in every mode
  AST_PWR_POS: assert property (
    power_in_valid && power_in.active >= 0 |=>
      power_out.active == $past(power_in.active))
    else $error("positive active power altered");
  // reactive keeps its magnitude, only the sign may flip
  AST_PWR_VAR: assert property (
    power_in_valid |=> power_out.reactive == $past(power_in.reactive) ||
      power_out.reactive == -$past(power_in.reactive))
    else $error("reactive magnitude altered");

  // main scenarios
  COV_WRITE: cover property (bvalid && bready);
  COV_BADRD: cover property (rvalid && rready && rresp == 2'h2);
  COV_IRQ: cover property ($rose(irq));
endmodule

// ---- energy_accum_noload_gain_config_tb.sv ----
`timescale 1ns/1ns
module energy_accum_noload_gain_config_tb;
  localparam logic [7:0] NL = meter_cfg_pkg::IDX_NOLOAD;
  localparam logic [7:0] AC = meter_cfg_pkg::IDX_ACCUM;
  localparam logic [7:0] GN = meter_cfg_pkg::IDX_GAIN;
  localparam logic [7:0] ST = meter_cfg_pkg::IDX_IRQ_STATUS;
  localparam logic [7:0] CL = meter_cfg_pkg::IDX_IRQ_CLEAR;
  localparam logic [7:0] EN = meter_cfg_pkg::IDX_IRQ_ENABLE;
  logic                       aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0;
  logic                       bready = 0, arvalid = 0, rready = 0;
  logic                       power_in_valid = 0, tamper_channel_b = 0;
  logic                       energy_pulse_output = 0, energy_pulse_neg = 0;
  logic                       reactive_pulse_output = 0;
  logic                       reactive_pulse_neg = 0;
  logic [9:0]                 awaddr = '0, araddr = '0;
  logic [31:0]                wdata = '0, rdata;
  logic [2:0]                 sg = '0;
  logic [1:0]                 bresp, rresp, rs;
  logic                       awready, wready, bvalid, arready, rvalid, irq;
  logic                       power_out_valid;
  meter_cfg_pkg::power_s      power_in = '0, power_out;
  meter_cfg_pkg::meter_cfg_s  cfg;
  int                         fails = 0, checks = 0, cyc = 0;

  // clock and hang guard
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish;
    end
  end

  energy_accum_noload_gain_config dut_u (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .power_in, .power_in_valid, .power_out, .power_out_valid,
    .active_power_neg(sg[0]), .reactive_power_neg(sg[1]), .fault_mode(sg[2]),
    .energy_pulse_output, .energy_pulse_neg, .reactive_pulse_output,
    .reactive_pulse_neg, .tamper_channel_b, .cfg, .irq);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // bus write, each channel released when taken
  task automatic wr(input logic [7:0] ix, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= {ix, 2'h0};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'h0;
  endtask

  // bus read and compare
  task automatic rdc(input logic [7:0] ix, input logic [31:0] e);
    @(posedge aclk);
    araddr <= {ix, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rs = rresp;
    rready <= 1'h0;
    chk(rdata, e);
  endtask

  task automatic t_reset;
    rdc(NL, 32'h0);
    rdc(AC, 32'h0);
    rdc(GN, 32'h0);
    rdc(8'h10, 32'h0);
    chk(32'(rs), 32'h2);
    wr(8'h10, 32'h5);
    chk(32'(rs), 32'h2);
    $display("test reset done");
  endtask

  task automatic t_noload;
    logic [15:0] ta [4] = '{16'h0, 16'h0bb8, 16'h05dc, 16'h02ee};
    logic [15:0] tp [4] = '{16'h0, 16'h05dc, 16'h02ee, 16'h0172};
    logic [7:0]  d;
    for (int c = 0; c < 4; c++) begin
      d = {c[1], c[0], c[1:0], c[1:0], c[1:0]};
      wr(NL, 32'(d));
      repeat (2) @(posedge aclk);
      chk(32'(cfg.apparent_th), 32'(ta[c]));
      chk(32'(cfg.reactive_th), 32'(tp[c]));
      chk(32'(cfg.active_th), 32'(tp[c]));
      chk(32'(cfg.current_rms_th), c[0] ? 32'(ta[c]) : 32'h0);
      chk(32'(cfg.current_rms_noload_enable), 32'(c[0]));
      chk(32'(cfg.var_freq_comp_enable), 32'(!c[1]));
      rdc(NL, 32'(d));
    end
    $display("test noload done");
  endtask

  task automatic t_accum;
    tamper_channel_b <= 1'h1;
    wr(AC, 32'hff);
    repeat (2) @(posedge aclk);
    rdc(AC, 32'hff);
    tamper_channel_b <= 1'h0;
    wr(AC, 32'h80);
    repeat (2) @(posedge aclk);
    rdc(AC, 32'h0);
    $display("test accum done");
  endtask

  task automatic t_gain;
    logic [7:0] d;
    for (int c = 0; c < 8; c++) begin
      d = {c[2:0], 1'h1, c[0], c[2:0]};
      wr(GN, 32'(d));
      repeat (2) @(posedge aclk);
      chk(32'(cfg.current_gain), c < 5 ? 32'h1 << c : 32'h1);
      chk(32'(cfg.voltage_gain), c < 5 ? 32'h1 << c : 32'h1);
      chk(32'(cfg.sign_detect_source), 32'(c[0]));
      rdc(GN, 32'(d & 8'hef));
    end
    wr(GN, 32'h0);
    $display("test gain done");
  endtask

  // each event, both polarities, wrong way, then masked
  task automatic t_sign;
    wr(EN, 32'h7);
    for (int e = 0; e < 3; e++) begin
      for (int p = 0; p < 2; p++) begin
        wr(AC, 32'(p) << (4 + e));
        sg[e] <= p[0];
        repeat (3) @(posedge aclk);
        wr(CL, 32'h7);
        sg[e] <= !p[0];
        repeat (3) @(posedge aclk);
        rdc(ST, 32'h1 << e);
        chk(32'(irq), 32'h1);
        wr(CL, 32'h7);
        sg[e] <= p[0];
        repeat (3) @(posedge aclk);
        rdc(ST, 32'h0);
        chk(32'(irq), 32'h0);
      end
    end
    wr(EN, 32'h0);
    sg[2] <= 1'h0;
    repeat (3) @(posedge aclk);
    rdc(ST, 32'h4);
    chk(32'(irq), 32'h0);
    $display("test sign done");
  endtask

  task automatic pulse(input logic n);
    @(posedge aclk);
    energy_pulse_output <= 1'h1;
    energy_pulse_neg <= n;
    reactive_pulse_output <= 1'h1;
    reactive_pulse_neg <= n;
    @(posedge aclk);
    energy_pulse_output <= 1'h0;
    reactive_pulse_output <= 1'h0;
  endtask

  task automatic t_pulse;
    wr(GN, 32'h08);
    wr(AC, 32'h0);
    wr(EN, 32'h7);
    wr(CL, 32'h7);
    pulse(1'h0);
    pulse(1'h1);
    repeat (3) @(posedge aclk);
    rdc(ST, 32'h3);
    wr(GN, 32'h0);
    $display("test pulse done");
  endtask

  task automatic t_power;
    logic [7:0]  m [5] = '{8'h0, 8'h1, 8'h2, 8'h8, 8'h4};
    logic [31:0] ea [5] = '{32'hfffffffb, 32'h5, 32'h0, 32'hfffffffb,
                            32'hfffffffb};
    logic [31:0] er [5] = '{32'hfffffff9, 32'hfffffff9, 32'hfffffff9,
                            32'h7, 32'h7};
    for (int i = 0; i < 5; i++) begin
      wr(AC, 32'(m[i]));
      repeat (2) @(posedge aclk);
      power_in <= {32'hfffffffb, 32'hfffffff9};
      power_in_valid <= 1'h1;
      @(posedge aclk);
      power_in_valid <= 1'h0;
      @(posedge aclk);
      chk(32'(power_out_valid), 32'h1);
      chk(power_out.active, ea[i]);
      chk(power_out.reactive, er[i]);
    end
    // positive active leaves reactive as it is
    power_in <= {32'h5, 32'hfffffff9};
    power_in_valid <= 1'h1;
    @(posedge aclk);
    power_in_valid <= 1'h0;
    @(posedge aclk);
    chk(power_out.active, 32'h5);
    chk(power_out.reactive, 32'hfffffff9);
    $display("test power done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // reset then scenarios
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_reset;
    t_noload;
    t_accum;
    t_gain;
    t_sign;
    t_pulse;
    t_power;
    tally_and_finish;
  end
endmodule

bind energy_accum_noload_gain_config
  energy_accum_noload_gain_config_properties chk_u (
    .aclk, .aresetn, .bvalid, .bready, .rvalid, .rready, .rresp,
    .power_in_valid, .power_out_valid, .power_in, .power_out, .irq, .cfg);
